// ---- verilog/ssi_pkg.sv ----
// Constants and carrier types of the supervision status and interrupt block.
// Function
// - Eight-bit status word, two bits per channel.
// - Bit A is debounced detector input one.
// - Bit B is input two or ground-key bit.
// - Status readable anytime, all channels at once.
// - GCI mode copies status into signaling octet.
// - Interrupt on unmasked change or armed transmit change.
// - Captured unmasked bits and interrupt hold until cleared.
// - Clearing read, mask write or reset clears.
// - Interrupt output totem-pole or open-drain, selectable.
// - Mask register blocks each status bit individually.
// - Activate command sets selected channels active.
// - Deactivate, soft reset, hard reset mean standby.
// - Chopper rate selectable, output only when enabled.
// - Full reset: pin, command, long chip select.
// - Reset selects A-law, ROM coefficients, zero gains.
// - Reset makes I/O inputs, clears tests, standby.
// - Reset sets slots 0-3, falling transmit edge.
// - Reset selects port A, fastest clock, channels enabled.
// - Reset clears pending, masks all, open drain, 8ms.
// - Reset: chopper low off, mux off, no signaling.
// - Loop filter restarts on change, waits programmed milliseconds.
// - Ground-key counter saturates 0..6, bypass when zero.
package ssi_pkg;
   localparam int CLK_HZ = 100000000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int NCH = 4;
   localparam int FRAMES_PER_MS = 8;
   localparam int MUX_WIDTH_NS = 31250;
   localparam int MUX_PERIOD_NS = 203125;
   localparam int MUX_GUARD_NS = 15625;
   localparam int MUX_WIDTH_CYC = MUX_WIDTH_NS / CLK_PERIOD_NS;
   localparam int MUX_PERIOD_CYC = MUX_PERIOD_NS / CLK_PERIOD_NS;
   localparam int MUX_GUARD_CYC = MUX_GUARD_NS / CLK_PERIOD_NS;
   localparam int CHOP_LO_HZ = 256000;
   localparam int CHOP_HI_DAHZ = 29257;
   localparam int CHOP_LO_HALF = CLK_HZ / CHOP_LO_HZ / 2;
   localparam int CHOP_HI_HALF = CLK_HZ / 10 / CHOP_HI_DAHZ / 2;
   localparam logic [4:0] CS_RESET_EDGES = 5'h10;
   localparam logic [7:0] OFF_STATUS = 8'h00;
   localparam logic [7:0] OFF_STATUS_CLR = 8'h01;
   localparam logic [7:0] OFF_MASK = 8'h02;
   localparam logic [7:0] OFF_CONFIG = 8'h03;
   localparam logic [7:0] OFF_DEBOUNCE = 8'h04;
   localparam logic [7:0] OFF_GK_LO = 8'h05;
   localparam logic [7:0] OFF_GK_HI = 8'h06;
   localparam logic [7:0] OFF_CHAN_EN = 8'h07;
   localparam logic [7:0] OFF_COMMAND = 8'h08;
   localparam logic [7:0] OFF_ARM_TX = 8'h09;
   localparam logic [7:0] OFF_CHAN_STATE = 8'h0A;
   localparam logic [7:0] OFF_AUX_BASE = 8'h10;
   localparam int AUX_N = 16;
   localparam int CFG_IRQ_OD_BIT = 0;
   localparam int CFG_CHOP_SEL_BIT = 1;
   localparam int CFG_CHOP_EN_BIT = 2;
   localparam int CFG_MUX_EN_BIT = 3;
   localparam int CFG_MUX_POL_BIT = 4;
   localparam int CFG_SIG_EN_BIT = 5;
   localparam logic [7:0] CFG_RESET = 8'h01;
   localparam logic [7:0] MASK_RESET = 8'hFF;
   localparam logic [3:0] DEBOUNCE_RESET = 4'h8;
   localparam logic [7:0] GK_RESET = 8'h00;
   localparam logic [3:0] CHAN_EN_RESET = 4'hF;
   localparam logic [7:0] CMD_DEACTIVATE = 8'h00;
   localparam logic [7:0] CMD_SOFT_RESET = 8'h02;
   localparam logic [7:0] CMD_FULL_RESET = 8'h04;
   localparam logic [7:0] CMD_ACTIVATE = 8'h0E;
   // Entry 0 is the lowest byte: coding, scaler, gains, I/O, tests, slots, ports, clock.
   localparam logic [AUX_N*8-1:0] AUX_RESET =
      128'h0F_00_00_03_02_01_00_03_02_01_00_00_00_00_00_00;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ssi_bus_req_t;
endpackage

// ---- verilog/ssi_supervision_status_interrupt.sv ----
// Supervision status word, interrupt, channel state, chopper and reset logic.
`timescale 1ns/10ps
module ssi_supervision_status_interrupt
#(
   parameter int MUX_PERIOD_CYC = ssi_pkg::MUX_PERIOD_CYC
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port
   input ssi_pkg::ssi_bus_req_t busReq,
   output logic [7:0] rdData,
   // Detector, frame and serial control pins
   input wire logic [3:0] slicDetectIn1,
   input wire logic [3:0] slicDetectIn2,
   input wire logic frameSyncIn,
   input wire logic chipSelN,
   input wire logic serialCmdClock,
   // Transmit path and mode
   input wire logic [3:0] txPcmChange,
   input wire logic gciMode,
   // Interrupt pin
   output logic irqNOut,
   output logic irqNOe,
   // Chopper and detector multiplex pins
   output logic chopperOut,
   output logic chopperOe,
   output logic detectorMuxPulse,
   output logic detectorMuxOe,
   // Status towards the rest of the device
   output logic [7:0] signalingControlOctet,
   output logic [3:0] channelActiveState,
   output logic [3:0] channelEnable,
   output logic pcmSignalingEn,
   output logic [ssi_pkg::AUX_N*8-1:0] auxCfg,
   output logic fullResetPulse
);

   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   localparam int SW = 11;
   logic [SW-1:0] pinS1_r, pinS2_r, pinS3_r, pinF_r;
   logic fsPrev_r, sclkPrev_r;
   wire [SW-1:0] pinRaw = {serialCmdClock, chipSelN, frameSyncIn, slicDetectIn2, slicDetectIn1};
   wire [SW-1:0] pinAgree = ~(pinS2_r ^ pinS3_r);
   wire [SW-1:0] pinF_nxt = (pinS2_r & pinAgree) | (pinF_r & ~pinAgree);
   wire [3:0] syncCd1 = pinF_r[3:0];
   wire [3:0] syncCd2 = pinF_r[7:4];
   wire fsTick = pinF_r[8] & ~fsPrev_r;
   wire csLow = ~pinF_r[9];
   wire sclkRise = pinF_r[10] & ~sclkPrev_r;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pinS1_r <= {2'b11, 9'h000};
         pinS2_r <= {2'b11, 9'h000};
         pinS3_r <= {2'b11, 9'h000};
         pinF_r <= {2'b11, 9'h000};
         fsPrev_r <= 1'b0;
         sclkPrev_r <= 1'b1;
      end
      else
      begin
         pinS1_r <= pinRaw;
         pinS2_r <= pinS1_r;
         pinS3_r <= pinS2_r;
         pinF_r <= pinF_nxt;
         fsPrev_r <= pinF_r[8];
         sclkPrev_r <= pinF_r[10];
      end
   end

   // -------------------------------------------------------------
   // Reset sources
   // -------------------------------------------------------------
   logic [4:0] csCnt_r;
   logic fullRstReq_r;
   logic cmdFullReset;
   wire csRstReq = csLow && sclkRise && (csCnt_r == ssi_pkg::CS_RESET_EDGES - 5'h01);
   wire srst = !rst_n || fullRstReq_r;

   always_ff @(posedge clk)
   begin
      if (!rst_n || !csLow)
         csCnt_r <= 5'h00;
      else if (sclkRise && csCnt_r != ssi_pkg::CS_RESET_EDGES)
         csCnt_r <= csCnt_r + 5'h01;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         fullRstReq_r <= 1'b0;
      else
         fullRstReq_r <= csRstReq || cmdFullReset;
   end
   assign fullResetPulse = fullRstReq_r;

   // -------------------------------------------------------------
   // Register file
   // -------------------------------------------------------------
   logic [7:0] mask_r, config_r, gkPeriod_lo_r, gkPeriod_hi_r, rdData_r;
   logic [3:0] loopDebounceTime_r, chanEn_r, armTransmitIrq_r, chanState_r;
   logic [7:0] capturedStatus_r, rdMux;
   logic [ssi_pkg::AUX_N*8-1:0] aux_r;
   wire [7:0] ad = busReq.addr;
   wire [7:0] wd = busReq.wdata;
   wire wrMask = busReq.wr && ad == ssi_pkg::OFF_MASK;
   wire wrConfig = busReq.wr && ad == ssi_pkg::OFF_CONFIG;
   wire wrDebounce = busReq.wr && ad == ssi_pkg::OFF_DEBOUNCE;
   wire wrGkLo = busReq.wr && ad == ssi_pkg::OFF_GK_LO;
   wire wrGkHi = busReq.wr && ad == ssi_pkg::OFF_GK_HI;
   wire wrChanEn = busReq.wr && ad == ssi_pkg::OFF_CHAN_EN;
   wire wrCmd = busReq.wr && ad == ssi_pkg::OFF_COMMAND;
   wire wrArmTx = busReq.wr && ad == ssi_pkg::OFF_ARM_TX;
   wire rdClr = busReq.rd && ad == ssi_pkg::OFF_STATUS_CLR;
   wire irqOutputTypeSel = config_r[ssi_pkg::CFG_IRQ_OD_BIT];
   wire chopperFreqSel = config_r[ssi_pkg::CFG_CHOP_SEL_BIT];
   wire chopperOutEn = config_r[ssi_pkg::CFG_CHOP_EN_BIT];
   wire muxEn = config_r[ssi_pkg::CFG_MUX_EN_BIT];
   wire muxPolLow = config_r[ssi_pkg::CFG_MUX_POL_BIT];
   wire [15:0] groundKeyPeriod = {gkPeriod_hi_r, gkPeriod_lo_r};
   assign cmdFullReset = wrCmd && wd == ssi_pkg::CMD_FULL_RESET;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         mask_r <= ssi_pkg::MASK_RESET;
         config_r <= ssi_pkg::CFG_RESET;
         loopDebounceTime_r <= ssi_pkg::DEBOUNCE_RESET;
         gkPeriod_lo_r <= ssi_pkg::GK_RESET;
         gkPeriod_hi_r <= ssi_pkg::GK_RESET;
         chanEn_r <= ssi_pkg::CHAN_EN_RESET;
         armTransmitIrq_r <= 4'h0;
      end
      else
      begin
         if (wrMask) mask_r <= wd;
         if (wrConfig) config_r <= wd;
         if (wrDebounce) loopDebounceTime_r <= wd[3:0];
         if (wrGkLo) gkPeriod_lo_r <= wd;
         if (wrGkHi) gkPeriod_hi_r <= wd;
         if (wrChanEn) chanEn_r <= wd[3:0];
         if (wrArmTx) armTransmitIrq_r <= wd[3:0];
      end
   end

   // Coding, slots, ports and clock settings; the coefficient RAM lives elsewhere and is kept.
   for (genvar i = 0; i < ssi_pkg::AUX_N; i++)
   begin : g_aux
      wire wrAux = busReq.wr && ad == ssi_pkg::OFF_AUX_BASE + 8'(i);
      always_ff @(posedge clk)
      begin
         if (srst)
            aux_r[8*i +: 8] <= ssi_pkg::AUX_RESET[8*i +: 8];
         else if (wrAux)
            aux_r[8*i +: 8] <= wd;
      end
   end
   assign auxCfg = aux_r;

   // Channel state: only the activate command can bring a channel up.
   always_ff @(posedge clk)
   begin
      if (srst)
         chanState_r <= 4'h0;
      else if (wrCmd && wd == ssi_pkg::CMD_ACTIVATE)
         chanState_r <= chanState_r | chanEn_r;
      else if (wrCmd && (wd == ssi_pkg::CMD_DEACTIVATE || wd == ssi_pkg::CMD_SOFT_RESET))
         chanState_r <= chanState_r & ~chanEn_r;
   end

   always_comb
   begin
      if (ad == ssi_pkg::OFF_STATUS || ad == ssi_pkg::OFF_STATUS_CLR)
         rdMux = capturedStatus_r;
      else if (ad == ssi_pkg::OFF_MASK)
         rdMux = mask_r;
      else if (ad == ssi_pkg::OFF_CONFIG)
         rdMux = config_r;
      else if (ad == ssi_pkg::OFF_DEBOUNCE)
         rdMux = {4'h0, loopDebounceTime_r};
      else if (ad == ssi_pkg::OFF_GK_LO)
         rdMux = gkPeriod_lo_r;
      else if (ad == ssi_pkg::OFF_GK_HI)
         rdMux = gkPeriod_hi_r;
      else if (ad == ssi_pkg::OFF_CHAN_EN)
         rdMux = {4'h0, chanEn_r};
      else if (ad == ssi_pkg::OFF_ARM_TX)
         rdMux = {4'h0, armTransmitIrq_r};
      else if (ad == ssi_pkg::OFF_CHAN_STATE)
         rdMux = {4'h0, chanState_r};
      else if (ad >= ssi_pkg::OFF_AUX_BASE && ad < ssi_pkg::OFF_AUX_BASE + 8'(ssi_pkg::AUX_N))
         rdMux = aux_r[8*(ad[3:0]) +: 8];
      else
         rdMux = 8'h00;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         rdData_r <= 8'h00;
      else
         rdData_r <= busReq.rd ? rdMux : 8'h00;
   end
   assign rdData = rdData_r;
   assign channelActiveState = chanState_r;
   assign channelEnable = chanEn_r;
   assign pcmSignalingEn = config_r[ssi_pkg::CFG_SIG_EN_BIT];

   // -------------------------------------------------------------
   // Detector multiplex pulse and input latches
   // -------------------------------------------------------------
   logic [15:0] muxCnt_r;
   logic muxOut_r;
   logic [3:0] cd1Lat_r, multiplexedGroundKeyBit_r;
   wire muxPulse = muxEn && muxCnt_r < 16'(ssi_pkg::MUX_WIDTH_CYC);
   // The detector output settles late, so each latch waits a guard time after the switch.
   wire ldEnable = !muxEn ||
      (!muxPulse && muxCnt_r >= 16'(ssi_pkg::MUX_WIDTH_CYC + ssi_pkg::MUX_GUARD_CYC));
   wire gkEnable = muxPulse && muxCnt_r >= 16'(ssi_pkg::MUX_GUARD_CYC);

   always_ff @(posedge clk)
   begin
      if (srst || !muxEn || muxCnt_r == 16'(MUX_PERIOD_CYC - 1))
         muxCnt_r <= 16'h0000;
      else
         muxCnt_r <= muxCnt_r + 16'h0001;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         muxOut_r <= 1'b0;
         cd1Lat_r <= 4'h0;
         multiplexedGroundKeyBit_r <= 4'h0;
      end
      else
      begin
         muxOut_r <= muxPulse ^ muxPolLow;
         if (ldEnable) cd1Lat_r <= syncCd1;
         if (gkEnable) multiplexedGroundKeyBit_r <= syncCd1;
      end
   end
   assign detectorMuxPulse = muxOut_r;
   assign detectorMuxOe = muxEn;

   // -------------------------------------------------------------
   // Debounce filters
   // -------------------------------------------------------------
   logic [2:0] frameCnt_r;
   logic [7:0] liveStatus;
   // Without frame sync neither filter advances, except a ground-key filter whose period is zero.
   wire msTick = fsTick && frameCnt_r == 3'(ssi_pkg::FRAMES_PER_MS - 1);

   always_ff @(posedge clk)
   begin
      if (srst)
         frameCnt_r <= 3'h0;
      else if (fsTick)
         frameCnt_r <= frameCnt_r + 3'h1;
   end

   for (genvar ch = 0; ch < ssi_pkg::NCH; ch++)
   begin : g_ch
      logic [3:0] ldCnt_r, gkTmr_r;
      logic [2:0] gkCnt_r;
      logic ldLast_r, debouncedDetectA_r, debouncedDetectB_r;
      wire ldIn = cd1Lat_r[ch];
      wire gkIn = muxEn ? multiplexedGroundKeyBit_r[ch] : syncCd2[ch];
      wire [3:0] gkPer = groundKeyPeriod[4*ch +: 4];
      wire gkTick = msTick && gkTmr_r == gkPer - 4'h1;
      wire [2:0] gkCnt_nxt = gkIn ? ((gkCnt_r == 3'h6) ? 3'h6 : gkCnt_r + 3'h1)
                                  : ((gkCnt_r == 3'h0) ? 3'h0 : gkCnt_r - 3'h1);
      always_ff @(posedge clk)
      begin
         if (srst)
         begin
            ldCnt_r <= 4'h0;
            ldLast_r <= 1'b0;
            debouncedDetectA_r <= 1'b0;
         end
         else if (fsTick)
         begin
            ldLast_r <= ldIn;
            if (ldIn != ldLast_r)
               ldCnt_r <= 4'h0;
            else if (msTick && ldCnt_r != 4'hF)
               ldCnt_r <= ldCnt_r + 4'h1;
            if (ldIn == ldLast_r && ldCnt_r >= loopDebounceTime_r)
               debouncedDetectA_r <= ldIn;
         end
      end
      always_ff @(posedge clk)
      begin
         if (srst)
         begin
            gkTmr_r <= 4'h0;
            gkCnt_r <= 3'h0;
            debouncedDetectB_r <= 1'b0;
         end
         else if (gkPer == 4'h0)
         begin
            gkTmr_r <= 4'h0;
            debouncedDetectB_r <= gkIn;
         end
         else if (msTick)
         begin
            gkTmr_r <= gkTick ? 4'h0 : gkTmr_r + 4'h1;
            if (gkTick)
            begin
               gkCnt_r <= gkCnt_nxt;
               if (gkCnt_nxt == 3'h6) debouncedDetectB_r <= 1'b1;
               else if (gkCnt_nxt == 3'h0) debouncedDetectB_r <= 1'b0;
            end
         end
      end
      assign liveStatus[2*ch] = debouncedDetectA_r;
      assign liveStatus[2*ch+1] = debouncedDetectB_r;
   end

   // -------------------------------------------------------------
   // Interrupt capture
   // -------------------------------------------------------------
   logic irqPend_r;
   logic [7:0] scOctet_r;
   wire [7:0] unmaskedDiff = (liveStatus ^ capturedStatus_r) & ~mask_r;
   wire txEvent = |(txPcmChange & armTransmitIrq_r);
   wire setEvent = (|unmaskedDiff) || txEvent;
   wire clrEvent = rdClr || wrMask;
   // A clear reloads the held word, so a change that came while pending retriggers at once.
   wire [7:0] capturedStatus_nxt = (!irqPend_r || clrEvent) ? liveStatus
      : ((liveStatus & mask_r) | (capturedStatus_r & ~mask_r));
   wire [7:0] capUnmasked = capturedStatus_r & ~mask_r;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         irqPend_r <= 1'b0;
         capturedStatus_r <= 8'h00;
      end
      else
      begin
         irqPend_r <= setEvent || (irqPend_r && !clrEvent);
         capturedStatus_r <= capturedStatus_nxt;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         scOctet_r <= 8'h00;
      else
         scOctet_r <= gciMode ? capturedStatus_r : 8'h00;
   end
   assign signalingControlOctet = scOctet_r;
   assign irqNOut = irqOutputTypeSel ? 1'b0 : !irqPend_r;
   assign irqNOe = irqOutputTypeSel ? irqPend_r : 1'b1;

   // -------------------------------------------------------------
   // Chopper clock
   // -------------------------------------------------------------
   logic [8:0] chopCnt_r;
   logic chopOut_r;
   wire [8:0] chopHalf = chopperFreqSel ? 9'(ssi_pkg::CHOP_HI_HALF) : 9'(ssi_pkg::CHOP_LO_HALF);

   always_ff @(posedge clk)
   begin
      if (srst || !chopperOutEn)
      begin
         chopCnt_r <= 9'h000;
         chopOut_r <= 1'b0;
      end
      else if (chopCnt_r >= chopHalf - 9'h001)
      begin
         chopCnt_r <= 9'h000;
         chopOut_r <= !chopOut_r;
      end
      else
         chopCnt_r <= chopCnt_r + 9'h001;
   end
   assign chopperOut = chopOut_r;
   assign chopperOe = chopperOutEn;

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence seqReadStatus;
      busReq.rd && (ad == ssi_pkg::OFF_STATUS || ad == ssi_pkg::OFF_STATUS_CLR);
   endsequence
   sequence seqActivate;
      wrCmd && wd == ssi_pkg::CMD_ACTIVATE;
   endsequence

   irq_raise_a: assert property ((|unmaskedDiff) |=> irqPend_r && !irqNOut && irqNOe)
      else $error("unmasked status change did not raise interrupt");
   tx_raise_a: assert property (txEvent |=> irqPend_r)
      else $error("armed transmit change did not raise interrupt");
   irq_hold_a: assert property (irqPend_r && !clrEvent |=> irqPend_r)
      else $error("interrupt dropped without clear");
   cap_hold_a: assert property (irqPend_r && !clrEvent |=> capUnmasked == $past(capUnmasked))
      else $error("captured unmasked bits moved while pending");
   irq_clear_a: assert property (irqPend_r && clrEvent && !setEvent |=> !irqPend_r)
      else $error("clear did not remove interrupt");
   od_drive_a: assert property (irqOutputTypeSel |-> !irqNOut && irqNOe == irqPend_r)
      else $error("open-drain interrupt pin drives high");
   mask_block_a: assert property (mask_r == 8'hFF && !txEvent && !irqPend_r |=> !irqPend_r)
      else $error("masked status raised interrupt");
   read_status_a: assert property (seqReadStatus |=> rdData == $past(capturedStatus_r))
      else $error("status read returned wrong value");
   activate_a: assert property (seqActivate ##1 1'b1 |-> (chanState_r & chanEn_r) == chanEn_r)
      else $error("activate left a selected channel in standby");
   chop_off_a: assert property (!chopperOutEn |-> !chopperOe ##1 !chopperOut)
      else $error("chopper runs while disabled");
   reset_state_a: assert property (disable iff (!rst_n) fullRstReq_r |=>
      mask_r == ssi_pkg::MASK_RESET && !irqPend_r && chanState_r == 4'h0 &&
      loopDebounceTime_r == ssi_pkg::DEBOUNCE_RESET)
      else $error("full reset left wrong state");

endmodule

// ---- test/ssi_frame_source.sv ----
// Frame sync source that stands in for the line card timing system.
`timescale 1ns/10ps
module ssi_frame_source
#(
   parameter int PERIOD = 40
)
(
   // Clock
   input wire logic clk,
   // Frame sync pin
   output logic frameSync
);
   int cnt = 0;
   initial frameSync = 1'b0;
   // Frames run free, because the loop filter and any ground-key filter with a nonzero period stall without them.
   always @(posedge clk)
   begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      frameSync <= (cnt < PERIOD / 2);
   end
endmodule

// ---- test/ssi_supervision_status_interrupt_bench.sv ----
// Self-checking bench of the supervision status and interrupt block.
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
   begin \
      totalChecks++; \
      if ((got) !== (ex)) \
      begin \
         miscompares++; \
         $display("BAD %s expected %h seen %h", nm, ex, got); \
      end \
   end
module ssi_supervision_status_interrupt_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   ssi_pkg::ssi_bus_req_t busReq = '0;
   logic [3:0] slicDetectIn1 = 4'h0, slicDetectIn2 = 4'h0, txPcmChange = 4'h0;
   logic frameSyncIn, chipSelN = 1'b1, serialCmdClock = 1'b0, gciMode = 1'b0;
   logic [7:0] rdData, signalingControlOctet;
   logic irqNOut, irqNOe, chopperOut, chopperOe, detectorMuxPulse, detectorMuxOe;
   logic [3:0] channelActiveState, channelEnable;
   logic pcmSignalingEn, fullResetPulse, hit, seenReset = 1'b0;
   logic [ssi_pkg::AUX_N*8-1:0] auxCfg;
   int miscompares = 0, totalChecks = 0, n;
   logic [23:0] rows [12] = '{24'h02A5A5, 24'h033E3E, 24'h040F0F, 24'h055A5A,
      24'h06C3C3, 24'h070505, 24'h090A0A, 24'h100101, 24'h1F8080, 24'h0F7700,
      24'h0AFF00, 24'h080E00};

   ssi_frame_source src
   (
      .clk(clk),
      .frameSync(frameSyncIn)
   );
   ssi_supervision_status_interrupt dut
   (
      .clk(clk), .rst_n(rst_n), .busReq(busReq), .rdData(rdData),
      .slicDetectIn1(slicDetectIn1), .slicDetectIn2(slicDetectIn2),
      .frameSyncIn(frameSyncIn), .chipSelN(chipSelN), .serialCmdClock(serialCmdClock),
      .txPcmChange(txPcmChange), .gciMode(gciMode), .irqNOut(irqNOut), .irqNOe(irqNOe),
      .chopperOut(chopperOut), .chopperOe(chopperOe), .detectorMuxPulse(detectorMuxPulse),
      .detectorMuxOe(detectorMuxOe), .signalingControlOctet(signalingControlOctet),
      .channelActiveState(channelActiveState), .channelEnable(channelEnable),
      .pcmSignalingEn(pcmSignalingEn), .auxCfg(auxCfg), .fullResetPulse(fullResetPulse)
   );

   initial
   begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
      if (fullResetPulse === 1'b1) seenReset <= 1'b1;

   // ----------------------------------------
   // Bus and check tasks
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      busReq <= {1'b1, 1'b0, a, d};
      @(posedge clk);
      busReq <= '0;
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      busReq <= {1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      busReq <= '0;
      #1 `CHK("register read", e, rdData)
   endtask
   task automatic waitIrq(input int lim);
      hit = 1'b0;
      for (int i = 0; i < lim && hit !== 1'b1; i++)
      begin
         @(posedge clk);
         #1 hit = irqNOe;
      end
   endtask
   task automatic pulseTx(input logic [3:0] v);
      @(posedge clk);
      txPcmChange <= v;
      @(posedge clk);
      txPcmChange <= 4'h0;
   endtask
   // The first half period after a rate change may be partial, so it is skipped.
   task automatic halfPer;
      logic v;
      for (int k = 0; k < 2; k++)
      begin
         #1 v = chopperOut;
         n = 0;
         while (chopperOut === v && n < 1000)
         begin
            @(posedge clk);
            #1 n++;
         end
      end
   endtask
   task automatic csEdges(input int k);
      repeat (k)
      begin
         repeat (3) @(posedge clk);
         serialCmdClock <= 1'b1;
         repeat (3) @(posedge clk);
         serialCmdClock <= 1'b0;
      end
      repeat (6) @(posedge clk);
   endtask
   task automatic chkReset;
      rdChk(8'h03, ssi_pkg::CFG_RESET);
      rdChk(8'h02, ssi_pkg::MASK_RESET);
      rdChk(8'h04, 8'h08);
      rdChk(8'h07, 8'h0F);
      rdChk(8'h0A, 8'h00);
      `CHK("aux settings", ssi_pkg::AUX_RESET, auxCfg)
      `CHK("irq pin", 2'b00, {irqNOe, irqNOut})
      `CHK("chopper mux signaling", 4'h0, {chopperOe, chopperOut, detectorMuxOe, pcmSignalingEn})
      `CHK("mux pulse", 1'b0, detectorMuxPulse)
      `CHK("channel enable pins", 4'hF, channelEnable)
   endtask
   task automatic printVerdict;
      $display("Checks %0d, mismatches %0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial
   begin
      repeat (40000) @(posedge clk);
      miscompares++;
      printVerdict();
   end
   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      chkReset();
      foreach (rows[i])
      begin
         wr(rows[i][23:16], rows[i][15:8]);
         rdChk(rows[i][23:16], rows[i][7:0]);
      end
      `CHK("mux and chopper enables", 2'h3, {detectorMuxOe, chopperOe})
      rdChk(8'h0A, 8'h05);
      wr(8'h08, ssi_pkg::CMD_DEACTIVATE);
      rdChk(8'h0A, 8'h00);
      wr(8'h08, ssi_pkg::CMD_ACTIVATE);
      #1 `CHK("state pins", 4'h5, channelActiveState)
      wr(8'h08, ssi_pkg::CMD_SOFT_RESET);
      rdChk(8'h0A, 8'h00);
      wr(8'h08, ssi_pkg::CMD_FULL_RESET);
      repeat (2) @(posedge clk);
      `CHK("command reset", 1'b1, seenReset)
      chkReset();
      wr(8'h04, 8'h00);
      wr(8'h02, 8'h00);
      slicDetectIn1 <= 4'h1;
      waitIrq(3000);
      `CHK("irq on change", 1'b1, hit)
      `CHK("open drain level", 1'b0, irqNOut)
      @(posedge clk) slicDetectIn2 <= 4'h1;
      repeat (1000) @(posedge clk);
      rdChk(8'h00, 8'h01);
      `CHK("irq held", 1'b1, irqNOe)
      rdChk(8'h01, 8'h01);
      waitIrq(20);
      `CHK("irq again", 1'b1, hit)
      rdChk(8'h01, 8'h03);
      @(posedge clk);
      #1 `CHK("irq cleared", 1'b0, irqNOe)
      wr(8'h02, 8'h04);
      slicDetectIn1 <= 4'h3;
      waitIrq(3000);
      `CHK("masked change", 1'b0, hit)
      rdChk(8'h00, 8'h07);
      wr(8'h09, 8'h02);
      pulseTx(4'h1);
      waitIrq(10);
      `CHK("unarmed transmit", 1'b0, hit)
      pulseTx(4'h2);
      waitIrq(10);
      `CHK("armed transmit", 1'b1, hit)
      wr(8'h02, 8'h04);
      #1 `CHK("mask write clears", 1'b0, irqNOe)
      wr(8'h03, 8'h00);
      #1 `CHK("totem pin", 2'b11, {irqNOe, irqNOut})
      @(posedge clk) gciMode <= 1'b1;
      repeat (2) @(posedge clk);
      #1 `CHK("signaling octet", 8'h07, signalingControlOctet)
      wr(8'h03, 8'h04);
      halfPer();
      `CHK("chopper low rate", ssi_pkg::CHOP_LO_HALF, n)
      wr(8'h03, 8'h06);
      halfPer();
      `CHK("chopper high rate", ssi_pkg::CHOP_HI_HALF, n)
      seenReset = 1'b0;
      @(posedge clk) chipSelN <= 1'b0;
      csEdges(15);
      `CHK("fifteen edges", 1'b0, seenReset)
      csEdges(1);
      chipSelN <= 1'b1;
      `CHK("chip select reset", 1'b1, seenReset)
      chkReset();
      printVerdict();
   end
endmodule
